/* File: core/acs_adc_ctrl.sv */
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
module acs_adc_ctrl #(
    parameter int unsigned CONV_TICKS = acs_pkg::ACS_CONV_TICKS
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_crystal_clock_tick,
    input wire logic i_stop,
    input wire logic [7:0] i_core_result,
    output logic o_core_start,
    output logic o_core_tick,
    output logic o_core_power_down,
    output acs_pkg::acs_mux_t o_core_mux,
    output logic o_conv_irq,
    output logic [7:0] o_pin_adc_owned
);
    import acs_pkg::*;

    if (CONV_TICKS < 2 || CONV_TICKS > 255) begin : g_check
        $error("CONV_TICKS must lie in 2..255");
    end

    localparam logic [7:0] LAST_TICK = 8'(CONV_TICKS - 1);

    acs_state_t state;
    logic run_req;
    logic [7:0] tick_cnt;
    logic conv_irq_enable;
    logic continuous_mode_bit;
    logic [4:0] channel_select;
    logic [2:0] clock_divider_select;
    logic clock_source_select;
    logic conversion_done_flag;
    logic [7:0] result;
    logic req;
    logic acc;
    logic ctrl_wr;
    logic clk_wr;
    logic result_rd;
    logic conv_end;
    logic src_tick;
    logic [4:0] wr_chan;
    logic [31:0] next_readdata;
    acs_mux_t next_mux;

    assign req = i_avs_read || i_avs_write;
    assign acc = req && !o_avs_waitrequest;
    assign ctrl_wr = acc && i_avs_write && i_avs_byteenable[0]
        && i_avs_address == ACS_OFF_CTRL;
    assign clk_wr = acc && i_avs_write && i_avs_byteenable[0]
        && i_avs_address == ACS_OFF_CLK;
    assign result_rd = acc && i_avs_read && i_avs_address == ACS_OFF_RESULT;
    assign wr_chan = i_avs_writedata[ACS_CH_LSB +: ACS_CH_W];
    // A control write in the final tick wins; that conversion is dropped
    assign conv_end = state == ACS_CONV && o_core_tick && tick_cnt == LAST_TICK
        && !i_stop && !ctrl_wr;
    assign src_tick = clock_source_select ? 1'b1 : i_crystal_clock_tick;
    assign next_mux = acs_decode_mux(channel_select);

    acs_prescaler u_prescaler (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_src_tick(src_tick),
        .i_restart(state == ACS_START),
        .i_div_sel(clock_divider_select),
        .o_tick(o_core_tick)
    );

    // One wait cycle per access keeps read data registered
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_avs_waitrequest <= 1'b1;
        end else if (req && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        next_readdata = 32'h0000_0000;
        if (i_avs_address == ACS_OFF_CTRL) begin
            next_readdata[ACS_BIT_DONE] = conversion_done_flag && !conv_irq_enable;
            next_readdata[ACS_BIT_IRQ_EN] = conv_irq_enable;
            next_readdata[ACS_BIT_CONT] = continuous_mode_bit;
            next_readdata[ACS_CH_LSB +: ACS_CH_W] = channel_select;
        end else if (i_avs_address == ACS_OFF_RESULT) begin
            next_readdata[7:0] = result;
        end else if (i_avs_address == ACS_OFF_CLK) begin
            next_readdata[ACS_DIV_LSB +: ACS_DIV_W] = clock_divider_select;
            next_readdata[ACS_BIT_SRC] = clock_source_select;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (req && o_avs_waitrequest && i_avs_read) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // Written done-flag bit is ignored
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            conv_irq_enable <= 1'b0;
            continuous_mode_bit <= 1'b0;
            channel_select <= ACS_CH_RESET;
        end else if (ctrl_wr) begin
            conv_irq_enable <= i_avs_writedata[ACS_BIT_IRQ_EN];
            continuous_mode_bit <= i_avs_writedata[ACS_BIT_CONT];
            channel_select <= wr_chan;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            clock_divider_select <= ACS_DIV_RESET;
            clock_source_select <= ACS_SRC_RESET;
        end else if (clk_wr) begin
            clock_divider_select <= i_avs_writedata[ACS_DIV_LSB +: ACS_DIV_W];
            clock_source_select <= i_avs_writedata[ACS_BIT_SRC];
        end
    end

    // Stop leaves run_req alone so the run resumes on exit
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= ACS_IDLE;
            run_req <= 1'b0;
        end else if (ctrl_wr) begin
            state <= ACS_IDLE;
            run_req <= wr_chan != ACS_CH_OFF;
        end else if (i_stop) begin
            state <= ACS_IDLE;
        end else begin
            case (state)
                ACS_IDLE: begin
                    if (run_req) begin
                        state <= ACS_START;
                    end
                end
                ACS_START: begin
                    state <= ACS_CONV;
                end
                ACS_CONV: begin
                    if (conv_end) begin
                        if (continuous_mode_bit) begin
                            state <= ACS_START;
                        end else begin
                            state <= ACS_IDLE;
                            run_req <= 1'b0;
                        end
                    end
                end
                default: begin
                    state <= ACS_IDLE;
                end
            endcase
        end
    end

    // The first tick may come early, giving 15 to 16 periods
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || state != ACS_CONV) begin
            tick_cnt <= 8'h00;
        end else if (o_core_tick) begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_core_start <= 1'b0;
        end else begin
            o_core_start <= state == ACS_START && !ctrl_wr && !i_stop;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            result <= 8'h00;
        end else if (conv_end) begin
            result <= i_core_result;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            conversion_done_flag <= 1'b0;
        end else if (conv_end && !conv_irq_enable) begin
            conversion_done_flag <= 1'b1;
        end else if (result_rd || (ctrl_wr && i_avs_writedata[ACS_BIT_IRQ_EN])) begin
            conversion_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_conv_irq <= 1'b0;
        end else if (conv_end && conv_irq_enable) begin
            o_conv_irq <= 1'b1;
        end else if (result_rd || ctrl_wr) begin
            o_conv_irq <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_core_mux <= '0;
            o_core_power_down <= 1'b1;
            o_pin_adc_owned <= 8'h00;
        end else begin
            o_core_mux <= next_mux;
            o_core_power_down <= channel_select == ACS_CH_OFF;
            o_pin_adc_owned <= next_mux.pin_en ? (8'h01 << next_mux.pin) : 8'h00;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_done_set;
        conv_end && !conv_irq_enable |=> conversion_done_flag;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done flag not set");

    property p_done_hidden;
        req && o_avs_waitrequest && i_avs_read && i_avs_address == ACS_OFF_CTRL
            && conv_irq_enable |=> !o_avs_readdata[ACS_BIT_DONE];
    endproperty
    a_done_hidden: assert property (p_done_hidden) else $error("done read as one");

    property p_irq_set;
        conv_end && conv_irq_enable |=> o_conv_irq && !conversion_done_flag;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("irq not raised");

    property p_irq_clear;
        o_conv_irq && (result_rd || ctrl_wr) && !conv_end |=> !o_conv_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("irq not dropped");

    property p_cont;
        conv_end && continuous_mode_bit ##1 !ctrl_wr && !i_stop |-> state == ACS_START
            ##1 o_core_start;
    endproperty
    a_cont: assert property (p_cont) else $error("continuous run stalled");

    property p_single;
        conv_end && !continuous_mode_bit |=> state == ACS_IDLE && !run_req;
    endproperty
    a_single: assert property (p_single) else $error("single run continued");

    property p_power_off;
        channel_select == ACS_CH_OFF && !ctrl_wr |=> state == ACS_IDLE;
    endproperty
    a_power_off: assert property (p_power_off) else $error("converted while off");

    property p_result;
        conv_end |=> result == $past(i_core_result);
    endproperty
    a_result: assert property (p_result) else $error("result not loaded");

    property p_restart;
        ctrl_wr && wr_chan != ACS_CH_OFF && !i_stop ##1 !i_stop && !ctrl_wr
            |=> state == ACS_START;
    endproperty
    a_restart: assert property (p_restart) else $error("write did not start");

    property p_stop;
        i_stop |=> state == ACS_IDLE && !o_core_start;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not abort");

endmodule // acs_adc_ctrl

/* File: core/acs_pkg.sv */
package acs_pkg;

    // Register byte offsets on the Avalon slave
    localparam logic [3:0] ACS_OFF_CTRL = 4'h0;
    localparam logic [3:0] ACS_OFF_RESULT = 4'h4;
    localparam logic [3:0] ACS_OFF_CLK = 4'h8;

    // Status/control field positions
    localparam int unsigned ACS_BIT_DONE = 7;
    localparam int unsigned ACS_BIT_IRQ_EN = 6;
    localparam int unsigned ACS_BIT_CONT = 5;
    localparam int unsigned ACS_CH_LSB = 0;
    localparam int unsigned ACS_CH_W = 5;

    // Clock config field positions
    localparam int unsigned ACS_DIV_LSB = 5;
    localparam int unsigned ACS_DIV_W = 3;
    localparam int unsigned ACS_BIT_SRC = 4;

    // Values after reset
    localparam logic [4:0] ACS_CH_RESET = 5'h1f;
    localparam logic [2:0] ACS_DIV_RESET = 3'h0;
    localparam logic ACS_SRC_RESET = 1'b0;

    // Channel codes
    localparam logic [4:0] ACS_CH_EXT_LAST = 5'h07;
    localparam logic [4:0] ACS_CH_REF_HIGH = 5'h1d;
    localparam logic [4:0] ACS_CH_REF_LOW = 5'h1e;
    localparam logic [4:0] ACS_CH_OFF = 5'h1f;

    // Converter clock cycles per conversion
    localparam int unsigned ACS_CONV_TICKS = 16;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_START = 2'b01,
        ACS_CONV = 2'b11
    } acs_state_t;

    typedef struct packed {
        logic [2:0] pin;
        logic pin_en;
        logic ref_high;
        logic ref_low;
    } acs_mux_t;

    // Reserved codes select nothing, so the core output is undefined
    function automatic acs_mux_t acs_decode_mux(input logic [4:0] ch);
        acs_mux_t m;
        m = '0;
        if (ch <= ACS_CH_EXT_LAST) begin
            m.pin = ch[2:0];
            m.pin_en = 1'b1;
        end else if (ch == ACS_CH_REF_HIGH) begin
            m.ref_high = 1'b1;
        end else if (ch == ACS_CH_REF_LOW) begin
            m.ref_low = 1'b1;
        end
        return m;
    endfunction

endpackage

/* File: core/acs_prescaler.sv */
`timescale 1ns/1ps
module acs_prescaler (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_src_tick,
    input wire logic i_restart,
    input wire logic [2:0] i_div_sel,
    output logic o_tick
);
    logic [3:0] count;

    // Last count value for each divide ratio
    function automatic logic [3:0] last_count(input logic [2:0] sel);
        logic [3:0] r;
        r = 4'hf;
        case (sel)
            3'h0: r = 4'h0;
            3'h1: r = 4'h1;
            3'h2: r = 4'h3;
            3'h3: r = 4'h7;
            default: r = 4'hf;
        endcase
        return r;
    endfunction

    // Compare with >= so a ratio change mid-count never waits a full wrap
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || i_restart) begin
            count <= 4'h0;
            o_tick <= 1'b0;
        end else begin
            o_tick <= 1'b0;
            if (i_src_tick) begin
                if (count >= last_count(i_div_sel)) begin
                    count <= 4'h0;
                    o_tick <= 1'b1;
                end else begin
                    count <= count + 4'h1;
                end
            end
        end
    end

endmodule // acs_prescaler

/* File: sim/acs_core_model.sv */
`timescale 1ns/1ps
// Analog core stand-in; while powered, holds what it sampled at each start pulse
module acs_core_model (
    input wire logic i_clk,
    input wire logic i_power_down,
    input wire logic i_start,
    input wire acs_pkg::acs_mux_t i_mux,
    input wire logic [63:0] i_analog,
    output logic [7:0] o_result
);
    import acs_pkg::*;
    initial o_result = 8'h5a;
    always @(posedge i_clk) begin
        if (i_power_down) begin
            o_result <= ~o_result; // Unpowered core gives no stable value
        end else if (i_start) begin
            if (i_mux.pin_en) begin
                o_result <= i_analog[i_mux.pin*8 +: 8];
            end else if (i_mux.ref_high) begin
                o_result <= 8'hff;
            end else if (i_mux.ref_low) begin
                o_result <= 8'h00;
            end else begin
                o_result <= ~o_result;
            end
        end
    end
endmodule // acs_core_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import acs_pkg::*;
    logic clk, rst_n, rd, wr, xtick, stop, wait_r, start, tick, pd, irq;
    logic [3:0] addr, be;
    logic [31:0] wdata, rdata;
    logic [7:0] core_res, owned, q, ev, b;
    logic [63:0] analog;
    logic [4:0] ch;
    logic [15:0] note;
    acs_mux_t mux;
    logic [15:0] expq[$];
    int failures = 0, n_tests = 0, n_starts = 0, n_ticks = 0, xcnt = 0, c0, i, d;
    // Short conversions keep the run brief
    acs_adc_ctrl #(.CONV_TICKS(4)) dut_u (
        .i_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
        .i_crystal_clock_tick(xtick), .i_stop(stop), .i_core_result(core_res),
        .o_core_start(start), .o_core_tick(tick), .o_core_power_down(pd),
        .o_core_mux(mux), .o_conv_irq(irq), .o_pin_adc_owned(owned)
    );
    acs_core_model core_u (
        .i_clk(clk), .i_power_down(pd), .i_start(start),
        .i_mux(mux), .i_analog(analog), .o_result(core_res)
    );
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Crystal enable every third cycle, unrelated to conversions
    always @(posedge clk) begin
        xcnt <= (xcnt == 2) ? 0 : xcnt + 1;
        xtick <= (xcnt == 2);
        n_starts <= n_starts + (start === 1'b1);
        n_ticks <= n_ticks + (tick === 1'b1);
    end
    task report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Oldest note against the data taken at the accepting edge
    always @(posedge clk) begin
        if (rd === 1'b1 && wait_r === 1'b0) begin
            note = expq.pop_front();
            if (note[15:8] != 8'h00) begin
                chk("readdata", note[7:0], rdata[7:0] & note[15:8]);
            end
        end
    end
    task bus(input logic w, input logic [3:0] a, input logic [7:0] dd, input logic [3:0] en);
        int t;
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, dd};
        be <= en;
        t = 0;
        do begin @(posedge clk); t++; end while (wait_r !== 1'b0 && t < 50);
        q = rdata[7:0];
        if (t >= 50) begin failures++; report_and_stop; end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] dd);
        bus(1'b1, a, dd, 4'h1);
    endtask
    task rd_exp(input logic [3:0] a, input logic [7:0] e);
        expq.push_back({8'hff, e});
        bus(1'b0, a, 8'h00, 4'h1);
    endtask
    task wait_for(input int w);
        int t;
        t = 0;
        do begin @(posedge clk); t++; end
        while ((w == 0 ? start : w == 1 ? irq : tick) !== 1'b1 && t < 400);
        if (t >= 400) begin failures++; report_and_stop; end
    endtask
    // Polls the done flag; polled reads carry no expectation
    task wait_done;
        int t;
        t = 0;
        do begin expq.push_back(16'h0); bus(1'b0, ACS_OFF_CTRL, 8'h00, 4'h1); t++; end
        while (q[7] !== 1'b1 && t < 40);
        if (t >= 40) begin failures++; report_and_stop; end
    endtask
    initial begin
        {rst_n, rd, wr, stop} = '0;
        addr = '0;
        be = '0;
        wdata = '0;
        void'($urandom(59483));
        analog = {$urandom, $urandom};
        analog[15:8] = ~analog[7:0];
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("power_down", 8'h01, {7'h0, pd});
        rd_exp(ACS_OFF_CTRL, 8'h1f);
        rd_exp(ACS_OFF_CLK, 8'h00);
        rd_exp(4'hc, 8'h00);
        bus(1'b1, ACS_OFF_CLK, 8'h10, 4'h0);
        rd_exp(ACS_OFF_CLK, 8'h00);
        wr_reg(ACS_OFF_CLK, 8'h10);
        // Settling conversion after power-off; its result is not trusted
        wr_reg(ACS_OFF_CTRL, 8'h00);
        wait_done;
        expq.push_back(16'h0);
        bus(1'b0, ACS_OFF_RESULT, 8'h00, 4'h1);
        for (i = 0; i < 10; i++) begin
            ch = (i < 8) ? 5'(i) : (i == 8) ? ACS_CH_REF_HIGH : ACS_CH_REF_LOW;
            ev = (i < 8) ? analog[i*8 +: 8] : (i == 8) ? 8'hff : 8'h00;
            c0 = n_starts;
            wr_reg(ACS_OFF_CTRL, {3'b000, ch}); // Done bit always written 0
            wait_done;
            chk("mux", (i < 8) ? {2'b00, ch[2:0], 3'b100} : {6'h0, i == 8, i == 9}, {2'b00, mux});
            chk("pin_owned", (i < 8) ? 8'h01 << i : 8'h00, owned);
            rd_exp(ACS_OFF_RESULT, ev);
            rd_exp(ACS_OFF_CTRL, {3'b000, ch});
            repeat (30) @(posedge clk);
            chk("starts", 8'h01, 8'(n_starts - c0));
        end
        // Reserved code still converts, but selects no pin and no reference
        wr_reg(ACS_OFF_CTRL, 8'h0c);
        wait_done;
        chk("mux_reserved", 8'h00, {2'b00, mux});
        chk("owned_reserved", 8'h00, owned);
        wr_reg(ACS_OFF_CTRL, 8'h43);
        wait_for(1);
        rd_exp(ACS_OFF_CTRL, 8'h43);
        chk("irq", 8'h01, {7'h0, irq});
        rd_exp(ACS_OFF_RESULT, analog[31:24]);
        chk("irq", 8'h00, {7'h0, irq});
        wr_reg(ACS_OFF_CTRL, 8'h43);
        wait_for(1);
        wr_reg(ACS_OFF_CTRL, 8'h43);
        chk("irq", 8'h00, {7'h0, irq});
        wr_reg(ACS_OFF_CTRL, 8'h00);
        wait_for(0);
        wr_reg(ACS_OFF_CTRL, 8'h01);
        wait_done;
        rd_exp(ACS_OFF_RESULT, analog[15:8]);
        wr_reg(ACS_OFF_CTRL, 8'h22);
        wait_for(0);
        c0 = n_ticks;
        wait_for(0);
        // Start to start spans the conversion plus the restart cycle: 4 or 5 ticks
        d = n_ticks - c0;
        chk("ticks", (d == 5) ? 8'h05 : 8'h04, 8'(d));
        b = 8'($urandom);
        analog[23:16] <= b;
        wait_for(0);
        wait_for(0);
        rd_exp(ACS_OFF_RESULT, b);
        // Bus source first, then the slower crystal enable
        for (i = 0; i < 16; i++) begin
            d = i % 8;
            wr_reg(ACS_OFF_CLK, {3'(d), i < 8, 4'h0});
            wr_reg(ACS_OFF_CTRL, 8'h22);
            wait_for(0);
            wait_for(2);
            c0 = 0;
            do begin @(posedge clk); c0++; end while (tick !== 1'b1 && c0 < 100);
            chk("tick_gap", 8'((i < 8 ? 1 : 3) << (d > 3 ? 4 : d)), 8'(c0));
        end
        wr_reg(ACS_OFF_CLK, 8'h10);
        wr_reg(ACS_OFF_CTRL, 8'h22);
        stop <= 1'b1;
        repeat (3) @(posedge clk);
        c0 = n_starts;
        repeat (60) @(posedge clk);
        chk("stop_starts", 8'h00, 8'(n_starts - c0));
        stop <= 1'b0;
        wait_for(0);
        wr_reg(ACS_OFF_CTRL, 8'h1f);
        c0 = n_starts;
        repeat (60) @(posedge clk);
        chk("off_starts", 8'h00, 8'(n_starts - c0));
        chk("power_down", 8'h01, {7'h0, pd});
        report_and_stop;
    end
endmodule // tb_top
